// ===== rtl/rss_pkg.sv
`default_nettype none
package rss_pkg;
  // register byte offsets
  localparam logic [7:0] RSS_OFS_CTRL = 8'h00;
  localparam logic [7:0] RSS_OFS_CAUSE = 8'h04;
  localparam logic [7:0] RSS_OFS_WDLOAD = 8'h08;
  localparam logic [7:0] RSS_OFS_WDCNT = 8'h0C;
  localparam logic [7:0] RSS_OFS_PRESC = 8'h10;
  localparam logic [7:0] RSS_OFS_PERIPH = 8'h14;
  localparam logic [7:0] RSS_OFS_RELOAD = 8'h18;
  // ctrl fields
  localparam int RSS_CTRL_WD_EN = 0;
  localparam int RSS_CTRL_WD_MODE = 1;
  localparam int RSS_CTRL_MON_OFF = 2;
  localparam int RSS_CTRL_IO_RST_OFF = 3;
  localparam int RSS_CTRL_BO_MASK_CORE = 4;
  localparam int RSS_CTRL_BO_MASK_IO = 5;
  localparam int RSS_CTRL_CLK_CFG = 8;
  // cause fields
  localparam int RSS_CAUSE_WD = 0;
  localparam int RSS_CAUSE_SUPPLY = 1;
  localparam int RSS_CAUSE_BO_CORE = 2;
  localparam int RSS_CAUSE_BO_IO = 3;
  // reset values, watchdog terminal count, reload key and boot address
  localparam logic [31:0] RSS_CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] RSS_WDLOAD_RST = 16'hFFFF;
  localparam logic [7:0] RSS_PRESC_RST = 8'h00;
  localparam logic [15:0] RSS_WD_TERMINAL = 16'h0000;
  localparam logic [31:0] RSS_RELOAD_KEY = 32'h0000_A5A5;
  localparam logic [31:0] RSS_START_ADDR = 32'h0000_0000;
  // timing
  localparam int RSS_CLK_MHZ = 200;
  localparam int RSS_POR_US = 1000;
  localparam int RSS_POR_CYC = RSS_POR_US * RSS_CLK_MHZ;
  localparam int RSS_RINMIN_NS = 100;
  localparam int RSS_RINMIN_CYC = (RSS_RINMIN_NS * RSS_CLK_MHZ + 999) / 1000;
endpackage
`default_nettype wire

// ===== rtl/rss_system_reset_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - global clear resets all but cause; system clear also spares clock unit.
// - core dropout, io dropout and power-up each raise global clear.
// - watchdog, board pin and debug command raise system clear only.
// - cause register records watchdog or supply; only power-up or a write-one-to-clear clears it.
// - separate brown-out warnings for core and io supplies.
// - mask bits can suppress every brown-out interrupt.
// - core dropout always raises global clear, never maskable.
// - io threshold level chosen by a non-volatile configuration input.
// - control bits suppress io dropout reset or disable monitor except core dropout.
// - 16-bit down-counter behind 8-bit prescaler, watchdog or free-run.
// - watchdog reaching zero unreloaded raises system clear.
// - watchdog disabled after every reset until firmware enables it.
// - board input low for minimum pulse width raises system clear.
// - board reset output low for the power-on duration.
// - hold reset until supplies good plus power-on time; boot at zero.
// - debug-port reset command raises system clear.
// - test port controllers reset on global clear or test-port reset.
// - firmware may reset any single peripheral at any time.
module rss_system_reset_supervisor
  import rss_pkg::*;
#(
  parameter int POR_CYC = RSS_POR_CYC,
  parameter int NPERIPH = 16
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_core_supply_ok,
  input wire logic i_io_supply_ok_low_thr,
  input wire logic i_io_supply_ok_high_thr,
  input wire logic i_core_sag,
  input wire logic i_io_sag,
  input wire logic i_io_thr_sel,
  input wire logic i_board_reset_input_low,
  input wire logic i_dbg_reset_cmd,
  input wire logic i_tap_reset_low,
  input wire logic i_tap_reset_cmd,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_global_clear,
  output logic o_system_clear,
  output logic o_tap_clear,
  output logic o_board_reset_output_low,
  output logic o_brownout_irq,
  output logic [NPERIPH-1:0] o_periph_clear,
  output logic [7:0] o_clock_unit_cfg,
  output logic [31:0] o_boot_addr
);

  localparam int PW = $clog2(POR_CYC + 1);
  localparam int MW = $clog2(RSS_RINMIN_CYC + 1);

  typedef enum logic [1:0] {RSS_POR, RSS_RUN, RSS_SYSRST} rss_state_t;

  logic [31:0] ctrl;
  logic [3:0] cause;
  logic [15:0] wd_load;
  logic [15:0] wd_cnt;
  logic [7:0] presc;
  logic [7:0] presc_cnt;
  logic [PW-1:0] por_cnt;
  logic [MW-1:0] pin_cnt;
  rss_state_t state;
  logic io_ok;
  logic gr_req;
  logic sr_req;
  logic wd_fire;
  logic pin_fire;
  logic apb_wr;
  logic apb_rd;
  logic reload_hit;
  logic tick;
  logic [31:0] next_prdata;

  ////////////////////////////////////////////////////////////////////////////
  // reset sources

  assign io_ok = i_io_thr_sel ? i_io_supply_ok_high_thr :
                 i_io_supply_ok_low_thr;
  // core dropout ignores every control bit; io dropout obeys them
  assign gr_req = !i_core_supply_ok
                | (!io_ok && !ctrl[RSS_CTRL_IO_RST_OFF]
                   && !ctrl[RSS_CTRL_MON_OFF]);
  assign pin_fire = (pin_cnt == MW'(RSS_RINMIN_CYC));
  assign sr_req = wd_fire | pin_fire | i_dbg_reset_cmd;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_cnt <= '0;
    end else if (i_board_reset_input_low) begin
      pin_cnt <= '0;
    end else if (!pin_fire) begin
      pin_cnt <= pin_cnt + MW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= RSS_POR;
      por_cnt <= '0;
    end else begin
      case (state)
        RSS_POR: begin
          // count restarts whenever a supply is still low
          if (gr_req) begin
            por_cnt <= '0;
          end else if (por_cnt == PW'(POR_CYC - 1)) begin
            state <= RSS_RUN;
          end else begin
            por_cnt <= por_cnt + PW'(1);
          end
        end
        RSS_RUN: begin
          if (gr_req) begin
            state <= RSS_POR;
            por_cnt <= '0;
          end else if (sr_req) begin
            state <= RSS_SYSRST;
          end
        end
        RSS_SYSRST: begin
          if (gr_req) begin
            state <= RSS_POR;
            por_cnt <= '0;
          end else if (!sr_req) begin
            state <= RSS_RUN;
          end
        end
        default: state <= RSS_POR;
      endcase
    end
  end

  // board pin follows global clear, so both last the power-on time
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_global_clear <= 1'b1;
    end else begin
      o_global_clear <= (state == RSS_POR) | gr_req;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_system_clear <= 1'b1;
    end else begin
      o_system_clear <= (state != RSS_RUN) | gr_req | sr_req;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_board_reset_output_low <= 1'b0;
    end else begin
      o_board_reset_output_low <= !((state == RSS_POR) | gr_req);
    end
  end

  // watchdog and board-pin clears leave the test port controllers alone
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_tap_clear <= 1'b1;
    end else begin
      o_tap_clear <= (state == RSS_POR) | gr_req | !i_tap_reset_low
                   | i_tap_reset_cmd;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_boot_addr <= RSS_START_ADDR;
    end else begin
      o_boot_addr <= RSS_START_ADDR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog

  assign tick = (presc_cnt == presc);
  assign reload_hit = apb_wr && (i_paddr == RSS_OFS_RELOAD)
                    && (i_pwdata == RSS_RELOAD_KEY);
  assign wd_fire = ctrl[RSS_CTRL_WD_EN] && !ctrl[RSS_CTRL_WD_MODE]
                 && tick && (wd_cnt == RSS_WD_TERMINAL + 16'h0001)
                 && !reload_hit;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      presc_cnt <= 8'h00;
      wd_cnt <= RSS_WDLOAD_RST;
    end else if (o_system_clear || reload_hit
                 || !ctrl[RSS_CTRL_WD_EN]) begin
      presc_cnt <= 8'h00;
      wd_cnt <= wd_load;
    end else if (tick) begin
      presc_cnt <= 8'h00;
      // free-run mode wraps at terminal count
      wd_cnt <= (wd_cnt == RSS_WD_TERMINAL) ? wd_load :
                wd_cnt - 16'h0001;
    end else begin
      presc_cnt <= presc_cnt + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states

  assign apb_wr = i_psel && i_penable && i_pwrite;
  assign apb_rd = i_psel && !i_penable && !i_pwrite;

  always_comb begin
    next_prdata = 32'h0000_0000;
    case (i_paddr)
      RSS_OFS_CTRL: next_prdata = ctrl;
      RSS_OFS_CAUSE: next_prdata = {28'h000_0000, cause};
      RSS_OFS_WDLOAD: next_prdata = {16'h0000, wd_load};
      RSS_OFS_WDCNT: next_prdata = {16'h0000, wd_cnt};
      RSS_OFS_PRESC: next_prdata = {24'h00_0000, presc};
      RSS_OFS_PERIPH: next_prdata = 32'(o_periph_clear);
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_prdata <= 32'h0000_0000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      // pready registered in setup, so access completes in one cycle
      o_pready <= i_psel && !i_penable;
      o_pslverr <= i_psel && !i_penable && (i_paddr[1:0] != 2'b00
                 || i_paddr > RSS_OFS_RELOAD);
      if (apb_rd) begin
        o_prdata <= next_prdata;
      end
    end
  end

  // system clear restores control; clock unit field only on global clear
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl <= RSS_CTRL_RST;
      wd_load <= RSS_WDLOAD_RST;
      presc <= RSS_PRESC_RST;
    end else if (o_global_clear) begin
      ctrl <= RSS_CTRL_RST;
      wd_load <= RSS_WDLOAD_RST;
      presc <= RSS_PRESC_RST;
    end else if (o_system_clear) begin
      ctrl <= {RSS_CTRL_RST[31:16], ctrl[15:8], RSS_CTRL_RST[7:0]};
      wd_load <= RSS_WDLOAD_RST;
      presc <= RSS_PRESC_RST;
    end else if (apb_wr) begin
      case (i_paddr)
        RSS_OFS_CTRL: ctrl <= {16'h0000, i_pwdata[15:8], 2'b00,
                               i_pwdata[5:0]};
        RSS_OFS_WDLOAD: wd_load <= i_pwdata[15:0];
        RSS_OFS_PRESC: presc <= i_pwdata[7:0];
        default: ctrl <= ctrl;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_clock_unit_cfg <= 8'h00;
    end else begin
      o_clock_unit_cfg <= ctrl[RSS_CTRL_CLK_CFG +: 8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset cause and brown-out; set wins over write-one-to-clear

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      cause <= 4'h0;
    end else if (state == RSS_POR && !i_core_supply_ok && !io_ok) begin
      cause <= 4'h0;
    end else begin
      for (int b = 0; b < 4; b++) begin
        if (apb_wr && i_paddr == RSS_OFS_CAUSE && i_pwdata[b]) begin
          cause[b] <= 1'b0;
        end
      end
      if (wd_fire) begin
        cause[RSS_CAUSE_WD] <= 1'b1;
      end
      if (gr_req && state != RSS_POR) begin
        cause[RSS_CAUSE_SUPPLY] <= 1'b1;
      end
      if (i_core_sag && !ctrl[RSS_CTRL_MON_OFF]) begin
        cause[RSS_CAUSE_BO_CORE] <= 1'b1;
      end
      if (i_io_sag && !ctrl[RSS_CTRL_MON_OFF]) begin
        cause[RSS_CAUSE_BO_IO] <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_brownout_irq <= 1'b0;
    end else begin
      o_brownout_irq <= (cause[RSS_CAUSE_BO_CORE]
                         && !ctrl[RSS_CTRL_BO_MASK_CORE])
                      | (cause[RSS_CAUSE_BO_IO]
                         && !ctrl[RSS_CTRL_BO_MASK_IO]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-peripheral clears

  genvar gp;
  generate
    for (gp = 0; gp < NPERIPH; gp++) begin : g_periph
      always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
          o_periph_clear[gp] <= 1'b0;
        end else if (o_system_clear) begin
          o_periph_clear[gp] <= 1'b0;
        end else if (apb_wr && i_paddr == RSS_OFS_PERIPH) begin
          o_periph_clear[gp] <= i_pwdata[gp];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ===== testbench/rss_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module rss_board_model (
  input wire logic i_clk,
  input wire logic i_go_board,
  input wire logic i_go_tap,
  input wire logic [7:0] i_len,
  output logic o_board_low,
  output logic o_tap_low
);
  logic [7:0] b_n = 8'h00;
  logic [7:0] t_n = 8'h00;
  // pins pulled up, so a released pin reads high
  assign o_board_low = (b_n == 8'h00);
  assign o_tap_low = (t_n == 8'h00);
  always @(posedge i_clk) begin
    b_n <= i_go_board ? i_len : b_n - (b_n != 8'h00);
    t_n <= i_go_tap ? i_len : t_n - (t_n != 8'h00);
  end
endmodule
`default_nettype wire

// ===== testbench/rss_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module rss_assertions
  import rss_pkg::*;
#(
  parameter int POR_CYC = 16
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_core_supply_ok,
  input wire logic i_board_reset_input_low,
  input wire logic i_dbg_reset_cmd,
  input wire logic i_tap_reset_low,
  input wire logic i_tap_reset_cmd,
  input wire logic o_global_clear,
  input wire logic o_system_clear,
  input wire logic o_tap_clear,
  input wire logic o_board_reset_output_low,
  input wire logic [31:0] o_boot_addr
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  int lo_n;
  int ok_n;
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      lo_n <= 0;
      ok_n <= 0;
    end else begin
      lo_n <= i_board_reset_input_low ? 0 : lo_n + 1;
      ok_n <= i_core_supply_ok ? ok_n + 1 : 0;
    end
  end
  sequence tap_quiet;
    i_tap_reset_low && !i_tap_reset_cmd && !o_global_clear;
  endsequence
  chk_glob_forces_sys: assert property (
    o_global_clear |-> o_system_clear)
    else $error("global clear without system clear");
  chk_board_out_low: assert property (
    o_global_clear |-> !o_board_reset_output_low)
    else $error("board output high in global clear");
  chk_tap_spared: assert property (
    tap_quiet ##1 tap_quiet ##1 tap_quiet |-> !o_tap_clear)
    else $error("tap clear without its causes");
  chk_tap_reset_src: assert property (
    (o_global_clear || !i_tap_reset_low || i_tap_reset_cmd)
    |-> ##[0:3] o_tap_clear)
    else $error("tap clear missing");
  chk_core_drop_glob: assert property (
    !i_core_supply_ok |-> ##[1:2] o_global_clear)
    else $error("core dropout without global clear");
  chk_dbg_cmd_sys: assert property (
    $rose(i_dbg_reset_cmd) |-> ##[1:3] o_system_clear)
    else $error("debug command without system clear");
  chk_board_min_sys: assert property (
    lo_n == RSS_RINMIN_CYC |-> ##[0:3] o_system_clear)
    else $error("board pulse without system clear");
  // one cycle of slack for the output register
  chk_por_hold_time: assert property (
    $fell(o_global_clear) |-> ok_n >= POR_CYC - 1)
    else $error("global clear released early");
  chk_boot_addr_fix: assert property (
    o_boot_addr == RSS_START_ADDR)
    else $error("boot address wrong");
endmodule
bind rss_system_reset_supervisor rss_assertions #(.POR_CYC(POR_CYC)) chk_u (
  .i_mclk(i_mclk), .i_nrst(i_nrst), .i_core_supply_ok(i_core_supply_ok),
  .i_board_reset_input_low(i_board_reset_input_low),
  .i_dbg_reset_cmd(i_dbg_reset_cmd), .i_tap_reset_low(i_tap_reset_low),
  .i_tap_reset_cmd(i_tap_reset_cmd), .o_global_clear(o_global_clear),
  .o_system_clear(o_system_clear), .o_tap_clear(o_tap_clear),
  .o_board_reset_output_low(o_board_reset_output_low),
  .o_boot_addr(o_boot_addr));
`default_nettype wire

// ===== testbench/rss_system_reset_supervisor_bench.sv
`timescale 1ns/1ps
`default_nettype none
module rss_system_reset_supervisor_bench;
  import rss_pkg::*;
  logic clk = '0, nrst = '0, core_ok = '0, io_lo = '0, io_hi = '0;
  logic core_sag = '0, io_sag = '0, thr_sel = '0, dbg = '0, tap_cmd = '0;
  logic psel = '0, penable = '0, pwrite = '0, go_b = '0, go_t = '0;
  logic pready, pslverr, gclr, sclr, tclr, bout_low, irq, perr, seen;
  logic board_low, tap_low;
  logic [7:0] paddr = '0, len = '0, ccfg, cfg;
  logic [31:0] pwdata = '0, prdata, boot, r, seed = 32'h5298_8b6e;
  logic [15:0] pclr, ld;
  logic [1:0] ps;
  int errors = 0, num_checks = 0, cyc = 0;
  rss_system_reset_supervisor #(.POR_CYC(16), .NPERIPH(16)) dut_u (
    .i_mclk(clk), .i_nrst(nrst), .i_core_supply_ok(core_ok),
    .i_io_supply_ok_low_thr(io_lo), .i_io_supply_ok_high_thr(io_hi),
    .i_core_sag(core_sag), .i_io_sag(io_sag), .i_io_thr_sel(thr_sel),
    .i_board_reset_input_low(board_low), .i_dbg_reset_cmd(dbg),
    .i_tap_reset_low(tap_low), .i_tap_reset_cmd(tap_cmd), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_global_clear(gclr), .o_system_clear(sclr),
    .o_tap_clear(tclr), .o_board_reset_output_low(bout_low),
    .o_brownout_irq(irq), .o_periph_clear(pclr),
    .o_clock_unit_cfg(ccfg), .o_boot_addr(boot));
  rss_board_model model_u (.i_clk(clk), .i_go_board(go_b), .i_go_tap(go_t),
    .i_len(len), .o_board_low(board_low), .o_tap_low(tap_low));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      complete_run();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // slack of two counts beyond the terminal value
  function automatic int wd_time(input logic [15:0] l, input logic [1:0] p);
    return (int'(l) + 2) * (int'(p) + 1) + 8;
  endfunction
  // waits for pready at a rising edge; only the bench timeout ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pause(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_sys(input logic v, input int lim);
    seen = 1'b0;
    for (int i = 0; i < lim && seen !== 1'b1; i++) begin
      @(negedge clk);
      seen = (sclr === v);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk) {core_ok, io_lo, io_hi} <= 3'b111;
    wait_sys(1'b0, 100);
    chk("por", seen, 1'b1);
    chk("bout", bout_low, 1'b1);
    apb(1'b0, RSS_OFS_CTRL, '0);
    chk("ctrl", r, RSS_CTRL_RST);
    apb(1'b0, RSS_OFS_CAUSE, '0);
    chk("cause", r, 32'h0000_0000);
    apb(1'b0, RSS_OFS_WDLOAD, '0);
    chk("wdload", r[15:0], RSS_WDLOAD_RST);
    apb(1'b0, 8'h1C, '0);
    chk("unmapped", perr, 1'b1);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) {io_sag, core_sag} <= 2'b01 << i;
      pause(3);
      chk("bo", irq, 1'b1);
      apb(1'b1, RSS_OFS_CTRL, 32'h0000_0030);
      pause(3);
      chk("bo_mask", irq, 1'b0);
      @(posedge clk) {io_sag, core_sag} <= 2'b00;
      apb(1'b1, RSS_OFS_CAUSE, 32'h0000_000C);
      apb(1'b1, RSS_OFS_CTRL, '0);
    end
    seed = lfsr(seed);
    apb(1'b1, RSS_OFS_PERIPH, {16'h0000, seed[15:0]});
    pause(2);
    chk("periph", pclr, seed[15:0]);
    apb(1'b1, RSS_OFS_PERIPH, '0);
    seed = lfsr(seed);
    ps = seed[1:0];
    ld = 16'h0008 + seed[5:2];
    cfg = seed[15:8];
    apb(1'b1, RSS_OFS_PRESC, {30'h0000_0000, ps});
    apb(1'b1, RSS_OFS_WDLOAD, {16'h0000, ld});
    apb(1'b1, RSS_OFS_CTRL, {16'h0000, cfg, 8'h03});
    apb(1'b1, RSS_OFS_RELOAD, RSS_RELOAD_KEY);
    wait_sys(1'b1, wd_time(ld, ps));
    chk("free_run", seen, 1'b0);
    chk("ccfg", ccfg, cfg);
    // reload first, so a stale free-run count cannot fire early
    apb(1'b1, RSS_OFS_RELOAD, RSS_RELOAD_KEY);
    apb(1'b1, RSS_OFS_CTRL, {16'h0000, cfg, 8'h01});
    wait_sys(1'b1, wd_time(ld, ps));
    chk("wd_fire", seen, 1'b1);
    chk("wd_glob", gclr, 1'b0);
    chk("wd_tap", tclr, 1'b0);
    wait_sys(1'b0, 50);
    apb(1'b0, RSS_OFS_CAUSE, '0);
    chk("cause_wd", r[RSS_CAUSE_WD], 1'b1);
    apb(1'b0, RSS_OFS_CTRL, '0);
    chk("wd_off", r[RSS_CTRL_WD_EN], 1'b0);
    chk("cfg_kept", r[15:8], cfg);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) go_b <= 1'b1;
      len <= i ? 8'h19 : 8'h0C;
      @(posedge clk) go_b <= 1'b0;
      wait_sys(1'b1, 40);
      chk("board_in", seen, i[0]);
      chk("board_tap", tclr, 1'b0);
      wait_sys(1'b0, 40);
    end
    @(posedge clk) dbg <= 1'b1;
    wait_sys(1'b1, 6);
    chk("dbg", seen, 1'b1);
    chk("dbg_glob", gclr, 1'b0);
    @(posedge clk) dbg <= 1'b0;
    wait_sys(1'b0, 20);
    @(posedge clk) go_t <= 1'b1;
    len <= 8'h04;
    @(posedge clk) go_t <= 1'b0;
    pause(3);
    chk("tap_pin", tclr, 1'b1);
    chk("tap_sys", sclr, 1'b0);
    pause(4);
    chk("tap_rel", tclr, 1'b0);
    @(posedge clk) tap_cmd <= 1'b1;
    @(posedge clk) tap_cmd <= 1'b0;
    pause(1);
    chk("tap_cmd", tclr, 1'b1);
    @(posedge clk) thr_sel <= 1'b1;
    io_hi <= 1'b0;
    pause(3);
    chk("io_drop", gclr, 1'b1);
    chk("io_tap", tclr, 1'b1);
    @(posedge clk) io_hi <= 1'b1;
    wait_sys(1'b0, 100);
    chk("cfg_clr", ccfg, 8'h00);
    apb(1'b0, RSS_OFS_CAUSE, '0);
    chk("cause_sup", r[RSS_CAUSE_SUPPLY], 1'b1);
    @(posedge clk) thr_sel <= 1'b0;
    io_hi <= 1'b0;
    wait_sys(1'b1, 10);
    chk("io_low_thr", seen, 1'b0);
    apb(1'b1, RSS_OFS_CTRL, 32'h0000_0004);
    @(posedge clk) io_lo <= 1'b0;
    wait_sys(1'b1, 10);
    chk("mon_off", seen, 1'b0);
    apb(1'b1, RSS_OFS_CTRL, 32'h0000_0008);
    wait_sys(1'b1, 10);
    chk("io_rst_off", seen, 1'b0);
    @(posedge clk) core_ok <= 1'b0;
    pause(3);
    chk("core_drop", gclr, 1'b1);
    @(posedge clk) {core_ok, io_lo, io_hi} <= 3'b111;
    wait_sys(1'b0, 100);
    apb(1'b0, RSS_OFS_CAUSE, '0);
    chk("cause_pwrup", r, 32'h0000_0000);
    complete_run();
  end
endmodule
`default_nettype wire
